// >>> rtl/pgs_pkg.sv
// package: register map, reset values, timing and state encoding for the pid gain/sequencing block
//
// Overview of operation
// - switch condition 0 always uses coefficient set 1.
// - condition 1: terminal inactive selects set 1, active selects set 2.
// - condition 2: absolute deviation below threshold set 1, above it set 2.
// - condition 3: pid output scaled to percent of max frequency against threshold.
// - threshold spans 0 to 100 percent, resets to zero, used only in 2 or 3.
// - regulator runs once per sampling period, 1 to 60000 ms, default 1 ms.
// - deviation within the dead band stops pid adjustment.
// - positive action: feedback below target raises output frequency.
// - negative action: feedback below target lowers output frequency.
// - after start, ramp at acceleration rate to initial output value.
// - hold initial value for hold time in 10 ms steps, then regulate.
// - negative output runs at zero frequency (policy 0) or reverses (policy 1).
// - reverse frequency is limited to the reverse cutoff frequency.
package pgs_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_THRESH = 8'h04;
	localparam logic [7:0] OFF_SAMPLE = 8'h08;
	localparam logic [7:0] OFF_DEADBAND = 8'h0C;
	localparam logic [7:0] OFF_INITVAL = 8'h10;
	localparam logic [7:0] OFF_HOLD = 8'h14;
	localparam logic [7:0] OFF_REVCUT = 8'h18;
	localparam logic [7:0] OFF_ACCEL = 8'h1C;
	localparam logic [7:0] OFF_MAXFREQ = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_FREQ = 8'h28;
	// control register field positions
	localparam int CTRL_COND_LSB = 0;
	localparam int CTRL_ACTION_BIT = 2;
	localparam int CTRL_POLICY_BIT = 3;
	// reset values
	localparam logic [1:0] RST_COND = 2'h0;
	localparam logic [9:0] RST_THRESH = 10'h000;
	localparam logic [15:0] RST_SAMPLE = 16'h0001;
	localparam logic [9:0] RST_DEADBAND = 10'h000;
	localparam logic [9:0] RST_INITVAL = 10'h000;
	localparam logic [15:0] RST_HOLD = 16'h0000;
	localparam logic [15:0] RST_REVCUT = 16'h00C8;
	localparam logic [15:0] RST_ACCEL = 16'h0001;
	localparam logic [15:0] RST_MAXFREQ = 16'h1388;
	// value limits
	localparam logic [15:0] MAX_SAMPLE_MS = 16'hEA60;
	localparam logic [9:0] MAX_PERCENT = 10'h3E8;
	localparam logic [9:0] MAX_DEADBAND = 10'h1F4;
	localparam logic [15:0] MAX_HOLD = 16'hEA60;
	localparam logic [31:0] PERCENT_FULL = 32'h000003E8;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_IN_NS = 1000000;
	localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
	localparam int HOLD_STEP_MS = 10;
	// sequencing states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RAMP = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_RUN = 4'b1000
	} pgs_state_t;
endpackage

// >>> rtl/pgs_gain_seq.sv
// module: pid coefficient-set selection, sampling, dead band, start-up ramp and output polarity
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pgs_gain_seq import pgs_pkg::*; #(
	parameter int msCycles = CYC_PER_MS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic runCommand,
	input wire logic digitalInputTerminal,
	input wire logic [9:0] targetValue,
	input wire logic [9:0] feedbackValue,
	input wire logic signed [16:0] pidOutput,
	output logic pidExecute,
	output logic coefSetSel,
	output logic signed [10:0] deviationOut,
	output logic [15:0] freqCommand,
	output logic reverseRun,
	output logic closedLoopActive
);

	typedef struct packed {
		pgs_state_t state;
		logic runMeta;
		logic runSync;
		logic termMeta;
		logic termSync;
		logic [15:0] msCnt;
		logic msTick;
		logic [15:0] sampCnt;
		logic [19:0] holdCnt;
		logic coefPending;
		logic coefSet;
		logic pidExec;
		logic signed [10:0] devOut;
		logic [15:0] freq;
		logic reverse;
		logic [1:0] gainSwitchCondition;
		logic actionDirection;
		logic negativeOutputPolicy;
		logic [9:0] gainSwitchThreshold;
		logic [15:0] samplingPeriod;
		logic [9:0] deviationDeadBand;
		logic [9:0] initialOutputValue;
		logic [15:0] initialHoldTime;
		logic [15:0] reverseCutoffFrequency;
		logic [15:0] accelStep;
		logic [15:0] maxFrequency;
		logic [31:0] rdData;
	} pgs_regs_t;

	pgs_regs_t q;
	pgs_regs_t d;

	// magnitude of a signed value
	function automatic logic [16:0] absVal(input logic signed [16:0] v);
		absVal = v[16] ? 17'(-v) : 17'(v);
	endfunction

	// smaller of two unsigned values
	function automatic logic [16:0] minVal(input logic [16:0] a, input logic [16:0] b);
		minVal = (a < b) ? a : b;
	endfunction

	logic signed [16:0] devRaw;
	logic [16:0] devAbs;
	logic [31:0] pidScaled;
	logic [31:0] threshScaled;
	logic [31:0] freqScaled;
	logic [31:0] initScaled;
	logic [16:0] freqSum;
	logic coefNext;

	// deviation and scaled comparisons
	always_comb begin
		devRaw = 17'(signed'({7'h00, targetValue})) - 17'(signed'({7'h00, feedbackValue}));
		devAbs = absVal(devRaw);
		pidScaled = pidOutput[16] ? 32'h00000000 : 32'({15'h0000, pidOutput[15:0]}) * PERCENT_FULL;
		threshScaled = 32'({22'h000000, q.gainSwitchThreshold}) * 32'({16'h0000, q.maxFrequency});
		freqScaled = 32'({16'h0000, q.freq}) * PERCENT_FULL;
		initScaled = 32'({22'h000000, q.initialOutputValue}) * 32'({16'h0000, q.maxFrequency});
		freqSum = 17'({1'b0, q.freq}) + 17'({1'b0, q.accelStep});
	end

	// coefficient set candidate for the current conditions
	always_comb begin
		case (q.gainSwitchCondition)
			2'h0: coefNext = 1'b0;
			2'h1: coefNext = q.termSync;
			2'h2: coefNext = devAbs > 17'({7'h00, q.gainSwitchThreshold});
			2'h3: coefNext = pidScaled > threshScaled;
			default: coefNext = 1'b0;
		endcase
	end

	// next-state logic for every register of the block
	always_comb begin
		d = q;
		d.runMeta = runCommand;
		d.runSync = q.runMeta;
		d.termMeta = digitalInputTerminal;
		d.termSync = q.termMeta;
		d.pidExec = 1'b0;
		d.msTick = 1'b0;
		d.rdData = 32'h00000000;

		// millisecond time base
		if (q.msCnt >= 16'(msCycles - 1)) begin
			d.msCnt = 16'h0000;
			d.msTick = 1'b1;
		end else begin
			d.msCnt = q.msCnt + 16'h0001;
		end

		// sampling period: one regulator execution per period
		if (q.msTick) begin
			if (q.sampCnt + 16'h0001 >= q.samplingPeriod) begin
				d.sampCnt = 16'h0000;
				if (q.state == ST_RUN && q.runSync) begin
					d.pidExec = 1'b1;
					d.coefSet = q.coefPending;
					d.coefPending = coefNext;
					// dead band and action direction
					if (devAbs <= 17'({7'h00, q.deviationDeadBand})) begin
						d.devOut = 11'sh000;
					end else if (q.actionDirection) begin
						d.devOut = 11'(-devRaw);
					end else begin
						d.devOut = 11'(devRaw);
					end
				end
			end else begin
				d.sampCnt = q.sampCnt + 16'h0001;
			end
		end

		// start-up sequencing and output frequency
		case (q.state)
			ST_IDLE: begin
				d.freq = 16'h0000;
				d.reverse = 1'b0;
				d.holdCnt = 20'h00000;
				d.sampCnt = 16'h0000;
				d.devOut = 11'sh000;
				d.coefPending = coefNext;
				d.coefSet = coefNext;
				if (q.runSync) begin
					d.state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (freqScaled >= initScaled) begin
					d.state = ST_HOLD;
				end else if (q.msTick) begin
					d.freq = (freqSum > 17'({1'b0, q.maxFrequency})) ? q.maxFrequency : freqSum[15:0];
				end
			end
			ST_HOLD: begin
				if (q.holdCnt >= 20'(32'(q.initialHoldTime) * HOLD_STEP_MS)) begin
					d.state = ST_RUN;
					d.sampCnt = 16'h0000;
				end else if (q.msTick) begin
					d.holdCnt = q.holdCnt + 20'h00001;
				end
			end
			ST_RUN: begin
				if (pidOutput[16]) begin
					d.reverse = q.negativeOutputPolicy;
					d.freq = q.negativeOutputPolicy ?
						16'(minVal(absVal(pidOutput), 17'({1'b0, q.reverseCutoffFrequency}))) :
						16'h0000;
				end else begin
					d.reverse = 1'b0;
					d.freq = 16'(minVal(17'(pidOutput), 17'({1'b0, q.maxFrequency})));
				end
			end
			default: d.state = ST_IDLE;
		endcase
		// a dropped run command stops the output in the same cycle as the state
		if (!q.runSync) begin
			d.state = ST_IDLE;
			d.freq = 16'h0000;
			d.reverse = 1'b0;
		end

		// register writes, out-of-range values are clamped
		if (regWr) begin
			case (regAddr)
				OFF_CTRL: begin
					d.gainSwitchCondition = regWrData[CTRL_COND_LSB +: 2];
					d.actionDirection = regWrData[CTRL_ACTION_BIT];
					d.negativeOutputPolicy = regWrData[CTRL_POLICY_BIT];
				end
				OFF_THRESH: d.gainSwitchThreshold = (regWrData[15:0] > 16'({6'h00, MAX_PERCENT})) ?
					MAX_PERCENT : regWrData[9:0];
				OFF_SAMPLE: d.samplingPeriod = (regWrData[15:0] == 16'h0000) ? RST_SAMPLE :
					((regWrData[15:0] > MAX_SAMPLE_MS) ? MAX_SAMPLE_MS : regWrData[15:0]);
				OFF_DEADBAND: d.deviationDeadBand = (regWrData[15:0] > 16'({6'h00, MAX_DEADBAND})) ?
					MAX_DEADBAND : regWrData[9:0];
				OFF_INITVAL: d.initialOutputValue = (regWrData[15:0] > 16'({6'h00, MAX_PERCENT})) ?
					MAX_PERCENT : regWrData[9:0];
				OFF_HOLD: d.initialHoldTime = (regWrData[15:0] > MAX_HOLD) ? MAX_HOLD : regWrData[15:0];
				OFF_REVCUT: d.reverseCutoffFrequency = regWrData[15:0];
				OFF_ACCEL: d.accelStep = regWrData[15:0];
				OFF_MAXFREQ: d.maxFrequency = regWrData[15:0];
				default: d.maxFrequency = q.maxFrequency;
			endcase
		end

		// register reads, data valid the following cycle
		if (regRd) begin
			case (regAddr)
				OFF_CTRL: d.rdData = {28'h0000000, q.negativeOutputPolicy, q.actionDirection, q.gainSwitchCondition};
				OFF_THRESH: d.rdData = {22'h000000, q.gainSwitchThreshold};
				OFF_SAMPLE: d.rdData = {16'h0000, q.samplingPeriod};
				OFF_DEADBAND: d.rdData = {22'h000000, q.deviationDeadBand};
				OFF_INITVAL: d.rdData = {22'h000000, q.initialOutputValue};
				OFF_HOLD: d.rdData = {16'h0000, q.initialHoldTime};
				OFF_REVCUT: d.rdData = {16'h0000, q.reverseCutoffFrequency};
				OFF_ACCEL: d.rdData = {16'h0000, q.accelStep};
				OFF_MAXFREQ: d.rdData = {16'h0000, q.maxFrequency};
				OFF_STATUS: d.rdData = {24'h000000, q.reverse, q.coefPending, q.coefSet, q.runSync, q.state};
				OFF_FREQ: d.rdData = {16'h0000, q.freq};
				default: d.rdData = 32'h00000000;
			endcase
		end

		// synchronous reset
		if (sys_rst) begin
			d = '0;
			d.state = ST_IDLE;
			d.gainSwitchCondition = RST_COND;
			d.gainSwitchThreshold = RST_THRESH;
			d.samplingPeriod = RST_SAMPLE;
			d.deviationDeadBand = RST_DEADBAND;
			d.initialOutputValue = RST_INITVAL;
			d.initialHoldTime = RST_HOLD;
			d.reverseCutoffFrequency = RST_REVCUT;
			d.accelStep = RST_ACCEL;
			d.maxFrequency = RST_MAXFREQ;
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// outputs straight from flip-flops
	assign regRdData = q.rdData;
	assign pidExecute = q.pidExec;
	assign coefSetSel = q.coefSet;
	assign deviationOut = q.devOut;
	assign freqCommand = q.freq;
	assign reverseRun = q.reverse;
	assign closedLoopActive = q.state[3];

endmodule

// >>> verif/pgs_gain_seq_monitor.sv
// checker: port timing checks for the pid gain and sequencing block
`timescale 1ns/1ps
module pgs_gain_seq_monitor import pgs_pkg::*; #(
	parameter int msCycles = CYC_PER_MS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic runCommand,
	input wire logic signed [16:0] pidOutput,
	input wire logic pidExecute,
	input wire logic coefSetSel,
	input wire logic signed [10:0] deviationOut,
	input wire logic [15:0] freqCommand,
	input wire logic reverseRun,
	input wire logic closedLoopActive
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// one execution per period, at least four cycles apart
	AST_EXEC_PULSE: assert property (pidExecute |=> !pidExecute [*3])
		else $error("execute pulses too close");
	AST_EXEC_RUN: assert property (pidExecute |-> closedLoopActive)
		else $error("execute outside closed loop");
	// positive output up to 1000 passes straight to the command
	AST_FWD_FREQ: assert property (closedLoopActive && pidOutput >= 0 && pidOutput <= 17'sh003E8 ##1 closedLoopActive
		|-> freqCommand == $past(pidOutput))
		else $error("forward command differs from pid output");
	AST_FWD_DIR: assert property (closedLoopActive && pidOutput >= 0 |=> !reverseRun)
		else $error("reverse with positive output");
	AST_REV_CAUSE: assert property (reverseRun |-> $past(pidOutput) < 0)
		else $error("reverse without negative output");
	// selection and deviation only move at an execution
	AST_HOLD_SEL: assert property (closedLoopActive && $past(closedLoopActive) && !pidExecute
		|-> $stable(coefSetSel) && $stable(deviationOut))
		else $error("selection changed between executions");
	AST_IDLE_ZERO: assert property (!runCommand [*4] |-> freqCommand == 16'h0000 && !closedLoopActive && !reverseRun)
		else $error("output while stopped");
	AST_RUN_START: assert property ($rose(closedLoopActive) |-> $past(runCommand, 3) && $past(runCommand, 4))
		else $error("closed loop without start");
endmodule
bind pgs_gain_seq pgs_gain_seq_monitor #(.msCycles(msCycles)) pgs_gain_seq_monitor_inst (.sys_clk, .sys_rst,
	.runCommand, .pidOutput, .pidExecute, .coefSetSel, .deviationOut, .freqCommand, .reverseRun, .closedLoopActive);

// >>> verif/pgs_drive_model.sv
// partner: pid arithmetic result and feedback sensor beside the block
`timescale 1ns/1ps
module pgs_drive_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pidExecute,
	input wire logic signed [16:0] pidSet,
	input wire logic [9:0] fbSet,
	output logic signed [16:0] pidOutput,
	output logic [9:0] feedbackValue
);
	// the regulator result only moves when an execution is requested
	always_ff @(posedge sys_clk) begin
		pidOutput <= sys_rst ? 17'h00000 : (pidExecute ? pidSet : pidOutput);
		feedbackValue <= fbSet;
	end
endmodule

// >>> verif/pgs_gain_seq_test.sv
// testbench: register, sequencing, selection and polarity tests
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin nErrors++; $display("[ERR] %0t mismatch", $time); end end
module pgs_gain_seq_test import pgs_pkg::*;;
	logic sys_clk = 0, sys_rst = 1, regWr = 0, regRd = 0, runCommand = 0, dit = 0;
	logic [7:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData;
	logic [9:0] targetValue = 0, fbSet = 0, feedbackValue;
	logic signed [16:0] pidSet = 0, pidOutput;
	logic pidExecute, coefSetSel, reverseRun, closedLoopActive;
	logic signed [10:0] deviationOut;
	logic [15:0] freqCommand, f;
	int nErrors = 0, nChecks = 0, n;
	always #12.5 sys_clk = ~sys_clk;
	pgs_gain_seq #(.msCycles(4)) pgs_gain_seq_inst (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .runCommand, .digitalInputTerminal(dit), .targetValue, .feedbackValue, .pidOutput,
		.pidExecute, .coefSetSel, .deviationOut, .freqCommand, .reverseRun, .closedLoopActive);
	pgs_drive_model pgs_drive_model_inst (.sys_clk, .sys_rst, .pidExecute, .pidSet, .fbSet, .pidOutput,
		.feedbackValue);
	task automatic conclude;
		$display("checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		`CHK(regRdData, e)
	endtask
	// waits for the next execution pulse, counting cycles
	task automatic nextExec(output int g);
		g = 0;
		do begin
			@(posedge sys_clk);
			#1;
			g++;
		end while (pidExecute !== 1'b1 && g < 400);
		if (pidExecute !== 1'b1) begin
			nErrors++;
			conclude();
		end
	endtask
	task automatic gsel(input logic [31:0] c, input logic [31:0] t, input logic d, input logic [16:0] p,
		input logic e);
		wr(OFF_CTRL, c);
		wr(OFF_THRESH, t);
		dit <= d;
		pidSet <= p;
		repeat (3) nextExec(n);
		`CHK(coefSetSel, e)
	endtask
	task automatic neg(input logic [31:0] c, input logic [16:0] p, input logic [15:0] ef, input logic er);
		wr(OFF_CTRL, c);
		pidSet <= p;
		repeat (2) nextExec(n);
		`CHK(freqCommand, ef)
		`CHK(reverseRun, er)
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(OFF_THRESH, 32'h0);
		rd(OFF_SAMPLE, 32'h1);
		rd(OFF_REVCUT, 32'hC8);
		rd(8'h30, 32'h0);
		wr(OFF_FREQ, 32'hFFFF);
		rd(OFF_FREQ, 32'h0);
		wr(OFF_SAMPLE, 32'h0);
		rd(OFF_SAMPLE, 32'h1);
		wr(OFF_SAMPLE, 32'hFFFF);
		rd(OFF_SAMPLE, 32'hEA60);
		wr(OFF_THRESH, 32'h7FF);
		rd(OFF_THRESH, 32'h3E8);
		wr(OFF_DEADBAND, 32'h3FF);
		rd(OFF_DEADBAND, 32'h1F4);
		wr(OFF_HOLD, 32'hFFFF);
		rd(OFF_HOLD, 32'hEA60);
		$display("test registers done");
		wr(OFF_DEADBAND, 32'h0);
		wr(OFF_SAMPLE, 32'h2);
		wr(OFF_INITVAL, 32'h64);
		wr(OFF_ACCEL, 32'h64);
		wr(OFF_HOLD, 32'h1);
		targetValue <= 10'h1F4;
		fbSet <= 10'h190;
		runCommand <= 1'b1;
		// ramp to 500 then hold 40 cycles before the loop closes
		for (n = 0; n < 200 && closedLoopActive !== 1'b1; n++) begin
			f = freqCommand;
			@(posedge sys_clk);
			#1;
		end
		`CHK(f, 16'h01F4)
		`CHK(n >= 56 && n <= 72, 1'b1)
		nextExec(n);
		nextExec(n);
		`CHK(n, 8)
		`CHK(deviationOut, 11'h064)
		`CHK(coefSetSel, 1'b0)
		wr(OFF_CTRL, 32'h4);
		repeat (2) nextExec(n);
		`CHK(deviationOut, 11'h79C)
		wr(OFF_DEADBAND, 32'h64);
		repeat (2) nextExec(n);
		`CHK(deviationOut, 11'h000)
		wr(OFF_DEADBAND, 32'h0);
		$display("test sequencing done");
		gsel(32'h0, 32'h0, 1'b1, 17'h00000, 1'b0);
		gsel(32'h1, 32'h0, 1'b0, 17'h00000, 1'b0);
		gsel(32'h1, 32'h0, 1'b1, 17'h00000, 1'b1);
		gsel(32'h2, 32'h32, 1'b0, 17'h00000, 1'b1);
		gsel(32'h2, 32'hC8, 1'b0, 17'h00000, 1'b0);
		gsel(32'h2, 32'h64, 1'b0, 17'h00000, 1'b0);
		gsel(32'h3, 32'h1F4, 1'b0, 17'h009C4, 1'b0);
		gsel(32'h3, 32'h1F3, 1'b0, 17'h009C4, 1'b1);
		$display("test gain select done");
		neg(32'h0, 17'h1FED4, 16'h0000, 1'b0);
		neg(32'h8, 17'h1FED4, 16'h00C8, 1'b1);
		neg(32'h8, 17'h1FF9C, 16'h0064, 1'b1);
		neg(32'h8, 17'h0012C, 16'h012C, 1'b0);
		$display("test polarity done");
		@(posedge sys_clk);
		runCommand <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(freqCommand, 16'h0000)
		`CHK(closedLoopActive, 1'b0)
		`CHK(reverseRun, 1'b0)
		$display("test stop done");
		conclude();
	end
endmodule
